// ---- hw/gdc_regs.svh ----
/*
 * Register offsets, reset values and field widths of the GPIO output drive control block.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef GDC_REGS_SVH
`define GDC_REGS_SVH

// ------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite register bus.
// ------------------------------------------------------------------
`define GDC_OFS_DRV_EN      8'h0c
`define GDC_OFS_DRV_EN_SET  8'h10
`define GDC_OFS_DRV_EN_CLR  8'h14
`define GDC_OFS_LEVEL       8'h18
`define GDC_OFS_LEVEL_SET   8'h1c
`define GDC_OFS_LEVEL_CLR   8'h20

// ------------------------------------------------------------------
// Reset values and widths.
// ------------------------------------------------------------------
`define GDC_RST_DRV_EN      32'h0000_0000
`define GDC_RST_LEVEL       32'h0000_0000
`define GDC_PINS            32
`define GDC_AW              8

// ------------------------------------------------------------------
// AXI response codes.
// ------------------------------------------------------------------
`define GDC_RESP_OKAY       2'h0
`define GDC_RESP_SLVERR     2'h2

`endif

// ---- hw/gdc_pkg.sv ----
/*
 * Types shared by the GPIO output drive control design.
 * Assumes gdc_regs.svh sits beside it on the include path.
 */
`include "gdc_regs.svh"

package gdc_pkg;

    // ------------------------------------------------------------------
    // Register selector produced by the address decoder.
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        GDC_SEL_NONE    = 3'b000,
        GDC_SEL_EN      = 3'b001,
        GDC_SEL_EN_SET  = 3'b010,
        GDC_SEL_EN_CLR  = 3'b011,
        GDC_SEL_LVL     = 3'b100,
        GDC_SEL_LVL_SET = 3'b101,
        GDC_SEL_LVL_CLR = 3'b110
    } gdc_sel_t;

    // Write channel progress of the bus slave.
    typedef enum logic [1:0]
    {
        GDC_WR_IDLE = 2'b00,
        GDC_WR_RESP = 2'b01
    } gdc_wr_st_t;

endpackage : gdc_pkg

// ---- hw/gdc_pin_drive.sv ----
/*
 * Per-pin output stage: combines level, driver enable and alternate function mux.
 * Assumes all inputs are synchronous to aclk; outputs are registered.
 */
`timescale 1ns/10ps
`include "gdc_regs.svh"

module gdc_pin_drive
(
    // Clock and reset.
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Register state.
    input  wire logic [`GDC_PINS-1:0]  level,
    input  wire logic [`GDC_PINS-1:0]  drv_en,
    // Alternate function hand-over.
    input  wire logic [`GDC_PINS-1:0]  alternate_function_sel,
    input  wire logic [`GDC_PINS-1:0]  alternate_function_out,
    input  wire logic [`GDC_PINS-1:0]  alternate_function_oe,
    // Pad side.
    output logic      [`GDC_PINS-1:0]  pad_out,
    output logic      [`GDC_PINS-1:0]  pad_oe
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [`GDC_PINS-1:0] out;  // Registered pad level.
        logic [`GDC_PINS-1:0] oe;   // Registered pad enable.
    } gdc_pd_st_t;

    gdc_pd_st_t st_r;   // Current state.
    gdc_pd_st_t st_nxt; // Next state.

    // Pins given to an alternate function ignore the level and enable
    // registers entirely; the peripheral owns both out and oe there.
    always_comb
    begin
        st_nxt.out = (alternate_function_sel & alternate_function_out)
                   | (~alternate_function_sel & level);
        st_nxt.oe  = (alternate_function_sel & alternate_function_oe)
                   | (~alternate_function_sel & drv_en);
    end

    // One register stage so the pads see glitch-free levels.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign pad_out = st_r.out;
    assign pad_oe  = st_r.oe;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    gpio_oe_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> pad_oe == $past((alternate_function_sel & alternate_function_oe)
                        | (~alternate_function_sel & drv_en)))
        else $error("Pad enable does not follow driver enable.");

    gpio_lvl_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> ((pad_out & ~$past(alternate_function_sel))
                            == ($past(level) & ~$past(alternate_function_sel)))
            && ((pad_out & $past(alternate_function_sel))
                == ($past(alternate_function_out) & $past(alternate_function_sel))))
        else $error("Pad level does not follow its source.");

endmodule : gdc_pin_drive

// ---- hw/gdc_top.sv ----
/*
 * GPIO output drive control: AXI4-Lite register file with driver enable and
 * output level registers plus their write-one-to-set and clear aliases.
 * Assumes a single 25 MHz aclk, synchronous active-low aresetn and a
 * well-behaved AXI4-Lite master with at most one read and one write in flight.
 */
`timescale 1ns/10ps
`include "gdc_regs.svh"

// Overview of operation
// - Enable set alias sets written one bits.
// - Enable clear alias clears written one bits.
// - Level bit drives pin high or low.
// - Level ignored without enable or alternate function.
// - Level set alias sets written one bits.
// - Level clear alias clears written one bits.
// - Enable bit switches pin driver on.
module gdc_top
(
    // Clock and reset.
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address channel.
    input  wire logic [`GDC_AW-1:0]    s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire logic [`GDC_AW-1:0]    s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Alternate function hand-over from other peripherals.
    input  wire logic [`GDC_PINS-1:0]  alternate_function_sel,
    input  wire logic [`GDC_PINS-1:0]  alternate_function_out,
    input  wire logic [`GDC_PINS-1:0]  alternate_function_oe,
    // Pad side.
    output logic      [`GDC_PINS-1:0]  pad_out,
    output logic      [`GDC_PINS-1:0]  pad_oe
);

    // ------------------------------------------------------------------
    // Functions.
    // ------------------------------------------------------------------

    // Map a byte address onto a register selector; unaligned or unknown
    // addresses fall to NONE and are answered with SLVERR.
    function automatic gdc_pkg::gdc_sel_t decode(input logic [`GDC_AW-1:0] addr);
        gdc_pkg::gdc_sel_t sel;
        sel = gdc_pkg::GDC_SEL_NONE;
        if (addr == `GDC_OFS_DRV_EN)
            sel = gdc_pkg::GDC_SEL_EN;
        else if (addr == `GDC_OFS_DRV_EN_SET)
            sel = gdc_pkg::GDC_SEL_EN_SET;
        else if (addr == `GDC_OFS_DRV_EN_CLR)
            sel = gdc_pkg::GDC_SEL_EN_CLR;
        else if (addr == `GDC_OFS_LEVEL)
            sel = gdc_pkg::GDC_SEL_LVL;
        else if (addr == `GDC_OFS_LEVEL_SET)
            sel = gdc_pkg::GDC_SEL_LVL_SET;
        else if (addr == `GDC_OFS_LEVEL_CLR)
            sel = gdc_pkg::GDC_SEL_LVL_CLR;
        return sel;
    endfunction : decode

    // Expand the four byte strobes into a 32-bit lane mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : lane_mask

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed
    {
        logic [`GDC_PINS-1:0]  drv_en;     // Pin driver enable register.
        logic [`GDC_PINS-1:0]  level;      // Output level register.
        logic                  aw_held;    // Write address captured.
        logic [`GDC_AW-1:0]    aw_addr;    // Captured write address.
        logic                  w_held;     // Write data captured.
        logic [31:0]           w_data;     // Captured write data.
        logic [3:0]            w_strb;     // Captured byte strobes.
        gdc_pkg::gdc_wr_st_t   wr_st;      // Write response progress.
        logic                  awready;    // Registered awready.
        logic                  wready;     // Registered wready.
        logic                  bvalid;     // Registered bvalid.
        logic [1:0]            bresp;      // Registered bresp.
        logic                  arready;    // Registered arready.
        logic                  rvalid;     // Registered rvalid.
        logic [31:0]           rdata;      // Registered rdata.
        logic [1:0]            rresp;      // Registered rresp.
    } gdc_st_t;

    gdc_st_t st_r;   // Current state.
    gdc_st_t st_nxt; // Next state.

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------

    // Address and data are captured independently, so the master may
    // present them in either order; the register update happens once
    // both are held, and the response is raised in the same cycle.
    always_comb
    begin
        gdc_pkg::gdc_sel_t wsel;
        gdc_pkg::gdc_sel_t rsel;
        logic [31:0]       mask;
        logic [31:0]       wbits;
        wsel   = gdc_pkg::GDC_SEL_NONE;
        rsel   = gdc_pkg::GDC_SEL_NONE;
        mask   = '0;
        wbits  = '0;
        st_nxt = st_r;

        // Write address capture; ready drops while held.
        if (s_axi_awvalid && st_r.awready)
        begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        // Write data capture.
        if (s_axi_wvalid && st_r.wready)
        begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        st_nxt.awready = !st_nxt.aw_held && (st_r.wr_st == gdc_pkg::GDC_WR_IDLE);
        st_nxt.wready  = !st_nxt.w_held  && (st_r.wr_st == gdc_pkg::GDC_WR_IDLE);

        case (st_r.wr_st)
            gdc_pkg::GDC_WR_IDLE:
            begin
                // Both halves present: commit and raise the response.
                if (st_r.aw_held && st_r.w_held)
                begin
                    wsel  = decode(st_r.aw_addr);
                    mask  = lane_mask(st_r.w_strb);
                    wbits = st_r.w_data & mask;
                    // A zero word into an alias ORs or masks nothing.
                    if (wsel == gdc_pkg::GDC_SEL_EN)
                        st_nxt.drv_en = (st_r.drv_en & ~mask) | wbits;
                    else if (wsel == gdc_pkg::GDC_SEL_EN_SET)
                        st_nxt.drv_en = st_r.drv_en | wbits;
                    else if (wsel == gdc_pkg::GDC_SEL_EN_CLR)
                        st_nxt.drv_en = st_r.drv_en & ~wbits;
                    else if (wsel == gdc_pkg::GDC_SEL_LVL)
                        st_nxt.level = (st_r.level & ~mask) | wbits;
                    else if (wsel == gdc_pkg::GDC_SEL_LVL_SET)
                        st_nxt.level = st_r.level | wbits;
                    else if (wsel == gdc_pkg::GDC_SEL_LVL_CLR)
                        st_nxt.level = st_r.level & ~wbits;
                    st_nxt.bvalid  = 1'b1;
                    st_nxt.bresp   = (wsel == gdc_pkg::GDC_SEL_NONE)
                                   ? `GDC_RESP_SLVERR : `GDC_RESP_OKAY;
                    st_nxt.aw_held = 1'b0;
                    st_nxt.w_held  = 1'b0;
                    st_nxt.awready = 1'b0;
                    st_nxt.wready  = 1'b0;
                    st_nxt.wr_st   = gdc_pkg::GDC_WR_RESP;
                end
            end
            gdc_pkg::GDC_WR_RESP:
            begin
                // Hold the response until the master takes it.
                if (s_axi_bready)
                begin
                    st_nxt.bvalid  = 1'b0;
                    st_nxt.awready = 1'b1;
                    st_nxt.wready  = 1'b1;
                    st_nxt.wr_st   = gdc_pkg::GDC_WR_IDLE;
                end
            end
            default:
            begin
                st_nxt.wr_st = gdc_pkg::GDC_WR_IDLE;
            end
        endcase

        // Read path: take the address, answer next cycle, hold until rready.
        if (st_r.rvalid)
        begin
            if (s_axi_rready)
            begin
                st_nxt.rvalid  = 1'b0;
                st_nxt.arready = 1'b1;
            end
        end
        else if (s_axi_arvalid && st_r.arready)
        begin
            rsel           = decode(s_axi_araddr);
            st_nxt.arready = 1'b0;
            st_nxt.rvalid  = 1'b1;
            st_nxt.rresp   = `GDC_RESP_OKAY;
            st_nxt.rdata   = '0; // Alias registers read back zero.
            if (rsel == gdc_pkg::GDC_SEL_EN)
                st_nxt.rdata = st_r.drv_en;
            else if (rsel == gdc_pkg::GDC_SEL_LVL)
                st_nxt.rdata = st_r.level;
            else if (rsel == gdc_pkg::GDC_SEL_NONE)
                st_nxt.rresp = `GDC_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------

    // Bits of pins that a variant lacks are stored like any other; keeping
    // them at reset is left to software, as the hardware cannot tell.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r         <= '0;
            st_r.drv_en  <= `GDC_RST_DRV_EN;
            st_r.level   <= `GDC_RST_LEVEL;
            st_r.wr_st   <= gdc_pkg::GDC_WR_IDLE;
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign s_axi_awready = st_r.awready;
    assign s_axi_wready  = st_r.wready;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = st_r.arready;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

    // Pad stage: applies enable and alternate function gating.
    gdc_pin_drive u_pin_drive
    (
        .aclk                   (aclk),
        .aresetn                (aresetn),
        .level                  (st_r.level),
        .drv_en                 (st_r.drv_en),
        .alternate_function_sel (alternate_function_sel),
        .alternate_function_out (alternate_function_out),
        .alternate_function_oe  (alternate_function_oe),
        .pad_out                (pad_out),
        .pad_oe                 (pad_oe)
    );

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    logic wr_fire; // Register commit this cycle.
    assign wr_fire = (st_r.wr_st == gdc_pkg::GDC_WR_IDLE) && st_r.aw_held && st_r.w_held;

    logic [31:0] wr_bits; // Strobed write data.
    assign wr_bits = st_r.w_data & lane_mask(st_r.w_strb);

    en_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_addr == `GDC_OFS_DRV_EN_SET
        |=> st_r.drv_en == ($past(st_r.drv_en) | $past(wr_bits)))
        else $error("Enable set alias did not set bits.");

    en_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_addr == `GDC_OFS_DRV_EN_CLR
        |=> st_r.drv_en == ($past(st_r.drv_en) & ~$past(wr_bits)))
        else $error("Enable clear alias did not clear bits.");

    lvl_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_addr == `GDC_OFS_LEVEL_SET
        |=> st_r.level == ($past(st_r.level) | $past(wr_bits)))
        else $error("Level set alias did not set bits.");

    lvl_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_addr == `GDC_OFS_LEVEL_CLR
        |=> st_r.level == ($past(st_r.level) & ~$past(wr_bits)))
        else $error("Level clear alias did not clear bits.");

    lvl_to_pad_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alternate_function_sel == '0) [*2] |-> pad_out == $past(st_r.level))
        else $error("Pad level does not match level register.");

    en_to_pad_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (alternate_function_sel == '0) [*2] |-> pad_oe == $past(st_r.drv_en))
        else $error("Pad enable does not match enable register.");

    alias_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !s_axi_rvalid
        && (s_axi_araddr == `GDC_OFS_LEVEL_SET || s_axi_araddr == `GDC_OFS_DRV_EN_CLR
            || s_axi_araddr == `GDC_OFS_LEVEL_CLR || s_axi_araddr == `GDC_OFS_DRV_EN_SET)
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `GDC_RESP_OKAY)
        else $error("Alias read returned nonzero data.");

    bresp_time_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid
            && ($past(wr_bits) != '0 || $past(st_r.aw_addr) == `GDC_OFS_DRV_EN
                || $past(st_r.aw_addr) == `GDC_OFS_LEVEL
                || ($stable(st_r.drv_en) && $stable(st_r.level))))
        else $error("Write response late or zero alias write changed state.");

    cov_en_set_c: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_addr == `GDC_OFS_DRV_EN_SET);
    cov_lvl_clr_c: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && st_r.aw_addr == `GDC_OFS_LEVEL_CLR);
    cov_read_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready);

endmodule : gdc_top

// ---- test/tb_gdc_top.sv ----
/*
 * Self-checking bench for the GPIO output drive control block.
 * Assumes the design files under hw/ and gdc_regs.svh on the include path.
 */
`timescale 1ns/10ps
`include "gdc_regs.svh"

module tb_gdc_top;

    // ------------------------------------------------------------------
    // Design connections and bench bookkeeping.
    // ------------------------------------------------------------------
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, af_sel, af_out, af_oe, pad_out, pad_oe;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] m_en, m_lvl;      // Expected register contents.
    int          n_errors = 0;
    int          compares = 0;

    gdc_top i_gdc_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .alternate_function_sel(af_sel), .alternate_function_out(af_out),
        .alternate_function_oe(af_oe), .pad_out(pad_out), .pad_oe(pad_oe));

    // Free-running 25 MHz clock.
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ------------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------------
    // Prints the verdict once; every path ends here.
    task automatic close_out();
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    // Compares one value with case equality so an unknown never matches.
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask : check

    // One AXI4-Lite write; an idle edge at the end keeps strobes from being
    // assigned twice in one time step by the next call.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        r = 2'h3;
        for (int i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask : axi_wr

    // One AXI4-Lite read, same hand-shake discipline as the write.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        d = 32'hxxxx_xxxx;
        r = 2'h3;
        for (int i = 0; i < 200; i++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        @(posedge aclk);
    endtask : axi_rd

    // Write, full-word unless strobes are given, expected to be accepted.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [1:0] r;
        axi_wr(a, d, s, r);
        check("bresp", {30'h0, `GDC_RESP_OKAY}, {30'h0, r});
    endtask : wr

    // Read and compare data and response.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check(nm, exp, d);
        check("rresp", {30'h0, `GDC_RESP_OKAY}, {30'h0, r});
    endtask : rd_chk

    // Pins: driver on where enabled and not handed over, or where handed over and af_oe is set; level only where driven.
    task automatic chk_pads();
        logic [31:0] eo;
        logic [31:0] ev;
        eo = (af_sel & af_oe) | (~af_sel & m_en);
        ev = ((af_sel & af_out) | (~af_sel & m_lvl)) & eo;
        check("pad_oe", eo, pad_oe);
        check("pad_out", ev, pad_out & eo);
    endtask : chk_pads

    // ------------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------------
    // All 32 bits are real pins here; none is held back.
    // Reset values of every register; aliases read zero.
    task automatic t_reset();
        rd_chk(`GDC_OFS_DRV_EN, 32'h0, "enable");
        rd_chk(`GDC_OFS_DRV_EN_SET, 32'h0, "en_set");
        rd_chk(`GDC_OFS_DRV_EN_CLR, 32'h0, "en_clr");
        rd_chk(`GDC_OFS_LEVEL, 32'h0, "level");
        rd_chk(`GDC_OFS_LEVEL_SET, 32'h0, "lvl_set");
        rd_chk(`GDC_OFS_LEVEL_CLR, 32'h0, "lvl_clr");
        chk_pads();
    endtask : t_reset

    // Enable register through its aliases, zero writes, and direct write.
    task automatic t_enable();
        wr(`GDC_OFS_DRV_EN_SET, 32'ha5a5_0f0f);
        m_en = 32'ha5a5_0f0f;
        rd_chk(`GDC_OFS_DRV_EN, m_en, "enable");
        wr(`GDC_OFS_DRV_EN_CLR, 32'h0000_ffff);
        m_en = 32'ha5a5_0000;
        rd_chk(`GDC_OFS_DRV_EN, m_en, "enable");
        wr(`GDC_OFS_DRV_EN_SET, 32'h0);
        wr(`GDC_OFS_DRV_EN_CLR, 32'h0);
        rd_chk(`GDC_OFS_DRV_EN, m_en, "enable");
        rd_chk(`GDC_OFS_DRV_EN_SET, 32'h0, "en_set");
        wr(`GDC_OFS_DRV_EN, 32'h1234_5678);
        m_en = 32'h1234_5678;
        rd_chk(`GDC_OFS_DRV_EN, m_en, "enable");
        chk_pads();
    endtask : t_enable

    // Level register: direct, set, clear, zero and strobed writes.
    task automatic t_level();
        wr(`GDC_OFS_LEVEL, 32'hf0f0_f0f0);
        m_lvl = 32'hf0f0_f0f0;
        chk_pads();
        wr(`GDC_OFS_LEVEL_SET, 32'h0000_000f);
        m_lvl = 32'hf0f0_f0ff;
        rd_chk(`GDC_OFS_LEVEL, m_lvl, "level");
        wr(`GDC_OFS_LEVEL_CLR, 32'hf000_0000);
        m_lvl = 32'h00f0_f0ff;
        rd_chk(`GDC_OFS_LEVEL, m_lvl, "level");
        wr(`GDC_OFS_LEVEL_SET, 32'h0);
        wr(`GDC_OFS_LEVEL_CLR, 32'h0);
        rd_chk(`GDC_OFS_LEVEL, m_lvl, "level");
        rd_chk(`GDC_OFS_LEVEL_CLR, 32'h0, "lvl_clr");
        wr(`GDC_OFS_LEVEL, 32'h0000_0000, 4'h2);
        m_lvl = 32'h00f0_00ff;
        rd_chk(`GDC_OFS_LEVEL, m_lvl, "level");
        chk_pads();
    endtask : t_level

    // Pins handed to the alternate function ignore level and enable.
    task automatic t_altfn();
        af_sel <= 32'h00ff_00f0;
        af_out <= 32'h5a5a_5a5a;
        af_oe  <= 32'h0f0f_0f0f;
        repeat (3) @(posedge aclk);
        chk_pads();
        af_sel <= 32'h0;
        repeat (3) @(posedge aclk);
        chk_pads();
    endtask : t_altfn

    // Unmapped and unaligned accesses are refused and change nothing.
    task automatic t_unmapped();
        logic [1:0]  r;
        logic [31:0] d;
        axi_wr(8'h24, 32'hffff_ffff, 4'hf, r);
        check("bresp", {30'h0, `GDC_RESP_SLVERR}, {30'h0, r});
        axi_wr(8'h0e, 32'hffff_ffff, 4'hf, r);
        check("bresp", {30'h0, `GDC_RESP_SLVERR}, {30'h0, r});
        rd_chk(`GDC_OFS_DRV_EN, m_en, "enable");
        axi_rd(8'h00, d, r);
        check("rresp", {30'h0, `GDC_RESP_SLVERR}, {30'h0, r});
        check("rdata", 32'h0, d);
    endtask : t_unmapped

    // Reset in mid-run brings registers and pads back to reset values.
    task automatic t_rerst();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        m_en  = `GDC_RST_DRV_EN;
        m_lvl = `GDC_RST_LEVEL;
        rd_chk(`GDC_OFS_DRV_EN, m_en, "enable");
        rd_chk(`GDC_OFS_LEVEL, m_lvl, "level");
        chk_pads();
    endtask : t_rerst

    // ------------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wstrb} = '0;
        {wdata, af_sel, af_out, af_oe, m_en, m_lvl} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_enable();
        t_level();
        t_altfn();
        t_unmapped();
        t_rerst();
        close_out();
    end

    // Whole run is under two hundred cycles; this span is far beyond it.
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end

endmodule : tb_gdc_top
